/* File: verilog/sfx_consts.svh */
// Constants of the FIFO expansion and configuration block
`ifndef SFX_CONSTS_SVH
`define SFX_CONSTS_SVH
`define SFX_WIDTH    18
`define SFX_DEPTH    8
`define SFX_AE_OFS   4'h2
`define SFX_AF_OFS   4'h2
`define SFX_HALF     4'h4
`define SFX_CFG_WAIT 2'h2
`define SFX_STRAP_RST 3'h7
`define SFX_FLAGS_RST 5'h0d
`endif

/* File: verilog/sfx_pkg.sv */
// Types of the FIFO expansion and configuration block
package sfx_pkg;
   // Operating mode caught from the straps
   typedef enum logic [1:0] {
      MD_STD,
      MD_FALL_THROUGH_MODE,
      MD_CHAIN
   } sfx_mode_t;
   // Strap and chain pins: first load, read chain in, write chain in
   typedef struct packed {
      logic fl;
      logic read_chain_in;
      logic write_chain_in;
   } sfx_strap_t;
   // Status flags, all active low
   typedef struct packed {
      logic empty_n;
      logic full_n;
      logic half_n;
      logic ae_n;
      logic af_n;
   } sfx_flags_t;
endpackage : sfx_pkg

/* File: verilog/sfx_chain.sv */
// FIFO buffer and strap-configured expansion logic
`include "sfx_consts.svh"
`timescale 1ns/1ps

module sfx_fifo import sfx_pkg::*; #(
   parameter int W = `SFX_WIDTH,
   parameter int D = `SFX_DEPTH,
   localparam int AW = $clog2(D),
   localparam int CW = $clog2(D + 1)
) (
   input  wire logic          i_clk,       // Core clock
   input  wire logic          i_rst,       // Async reset, high
   input  wire logic          i_in_valid,  // Word offered
   output logic               o_in_ready,  // Room for a word
   input  wire logic [W-1:0]  i_in_data,   // Word in
   output logic               o_out_valid, // Word held
   input  wire logic          i_out_ready, // Drain takes word
   output logic [W-1:0]       o_out_data,  // Oldest word
   output logic [CW-1:0]      o_count,     // Words held
   output logic               o_wr_last,   // Push to last slot
   output logic               o_rd_last    // Pop from last slot
);
   logic [W-1:0]  mem [D];             // Storage array
   logic [AW-1:0] wptr_q, wptr_d;      // Write pointer
   logic [AW-1:0] rptr_q, rptr_d;      // Read pointer
   logic [CW-1:0] cnt_q, cnt_d;        // Fill level
   logic          push, pop;           // Handshakes

   // Handshakes and next pointers
   always_comb begin
      o_in_ready  = (cnt_q != CW'(D));
      o_out_valid = (cnt_q != '0);
      push        = i_in_valid & o_in_ready;
      pop         = o_out_valid & i_out_ready;
      o_wr_last   = push & (wptr_q == AW'(D - 1));
      o_rd_last   = pop & (rptr_q == AW'(D - 1));
      wptr_d      = wptr_q;
      rptr_d      = rptr_q;
      cnt_d       = cnt_q;
      if (push) begin
         wptr_d = o_wr_last ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
         rptr_d = o_rd_last ? '0 : rptr_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      o_out_data = mem[rptr_q];
      o_count    = cnt_q;
   end

   // Pointer and level registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q  <= cnt_d;
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wptr_q] <= i_in_data;
      end
   end
endmodule : sfx_fifo

module sfx_chain import sfx_pkg::*; (
   input  wire logic        i_core_clk,         // Core clock
   input  wire logic        i_sys_rst,          // Async reset, high
   input  wire logic        i_wr_en,            // Write request
   input  wire logic [17:0] i_wr_data,          // Write word
   input  wire logic        i_rd_en,            // Read request
   input  wire logic        i_first_load_strap, // First load strap
   input  wire logic        i_read_chain_in_n,  // Read chain in
   input  wire logic        i_write_chain_in_n, // Write chain in
   output logic      [17:0] o_rd_data,          // Read word
   output logic             o_empty_flag_n,     // Empty / out ready
   output logic             o_full_flag_n,      // Full / input ready
   output logic             o_half_full_flag_n, // Half full
   output logic             o_almost_empty_flag_n, // Almost empty
   output logic             o_almost_full_flag_n,  // Almost full
   output logic             o_write_chain_out_n,   // Write token out
   output logic             o_read_chain_out_n     // Read token out
);
   sfx_strap_t  s1_q, s2_q;            // Pin synchroniser
   sfx_mode_t   mode_q, mode_d;        // Operating mode
   logic        dbl_q, dbl_d;          // Double-stage flags
   logic [1:0]  wait_q, wait_d;        // Strap settle count
   logic        cfg_q, cfg_d;          // Mode captured
   logic        wtok_q, wtok_d;        // Holds write token
   logic        rtok_q, rtok_d;        // Holds read token
   logic        ov_q, ov_d;            // Fall-through word shown
   logic [17:0] rdat_q, rdat_d;        // Output word
   sfx_flags_t  st1_q, st1_d;          // First flag stage
   sfx_flags_t  flg_q, flg_d;          // Flag outputs
   logic        wxo_q, wxo_d;          // Write token pulse
   logic        rxo_q, rxo_d;          // Read token pulse
   logic        in_valid, in_ready;    // Fill side
   logic        out_valid, out_ready;  // Drain side
   logic [17:0] out_data;              // Oldest word
   logic [3:0]  count;                 // Fill level
   logic        wr_last, rd_last;      // Last slot events
   logic        chain, fall_through_mode;           // Mode decode
   sfx_flags_t  raw;                   // Flags from level

   // Two-flop synchroniser for straps and chain pins
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s1_q <= `SFX_STRAP_RST;
         s2_q <= `SFX_STRAP_RST;
      end else begin
         s1_q <= {i_first_load_strap, i_read_chain_in_n,
                  i_write_chain_in_n};
         s2_q <= s1_q;
      end
   end

   // Buffer in the data path
   sfx_fifo #(.W(`SFX_WIDTH), .D(`SFX_DEPTH)) u_buf (
      .i_clk       (i_core_clk),
      .i_rst       (i_sys_rst),
      .i_in_valid  (in_valid),
      .o_in_ready  (in_ready),
      .i_in_data   (i_wr_data),
      .o_out_valid (out_valid),
      .i_out_ready (out_ready),
      .o_out_data  (out_data),
      .o_count     (count),
      .o_wr_last   (wr_last),
      .o_rd_last   (rd_last)
   );

   // Next state of configuration, tokens, data and flags
   always_comb begin
      chain  = (mode_q == MD_CHAIN);
      fall_through_mode   = (mode_q == MD_FALL_THROUGH_MODE);
      mode_d = mode_q;
      dbl_d  = dbl_q;
      wait_d = wait_q;
      cfg_d  = cfg_q;
      wtok_d = wtok_q;
      rtok_d = rtok_q;
      // Straps caught once they have crossed the synchroniser
      if (!cfg_q) begin
         if (wait_q == `SFX_CFG_WAIT) begin
            cfg_d = 1'b1;
            // standalone unless both chain pins high
            if (s2_q.read_chain_in && s2_q.write_chain_in) begin
               mode_d = MD_CHAIN;
            end else if (!s2_q.read_chain_in && s2_q.write_chain_in) begin
               mode_d = MD_FALL_THROUGH_MODE;
            end else begin
               mode_d = MD_STD;
            end
            dbl_d  = s2_q.read_chain_in & !s2_q.write_chain_in;
            // first device starts with both tokens
            wtok_d = !(s2_q.read_chain_in && s2_q.write_chain_in) || !s2_q.fl;
            rtok_d = !(s2_q.read_chain_in && s2_q.write_chain_in) || !s2_q.fl;
         end else begin
            wait_d = wait_q + 2'h1;
         end
      end
      // writes only while holding write token
      in_valid = cfg_q & i_wr_en & (!chain | wtok_q);
      // Fall-through keeps one word in the output register
      if (fall_through_mode) begin
         out_ready = !ov_q | i_rd_en;
      end else begin
         // reads only while holding read token
         out_ready = cfg_q & i_rd_en & (!chain | rtok_q);
      end
      ov_d   = ov_q;
      rdat_d = rdat_q;
      if (fall_through_mode) begin
         // head word drops straight into the output
         if (!ov_q || i_rd_en) begin
            ov_d = out_valid;
            if (out_valid) begin
               rdat_d = out_data;
            end
         end
      end else if (out_valid && out_ready) begin
         rdat_d = out_data;
      end
      // write token leaves at last location
      wxo_d = !wr_last;
      // read token leaves at last location
      rxo_d = !rd_last;
      if (chain && wr_last) begin
         wtok_d = 1'b0;
      end else if (chain && cfg_q && !s2_q.write_chain_in) begin
         wtok_d = 1'b1;
      end
      if (chain && rd_last) begin
         rtok_d = 1'b0;
      end else if (chain && cfg_q && !s2_q.read_chain_in) begin
         rtok_d = 1'b1;
      end
      // Flags from the present fill level
      raw.empty_n = (count != 4'h0);
      raw.full_n  = (count != 4'(`SFX_DEPTH));
      raw.half_n  = !(count > `SFX_HALF);
      raw.ae_n    = !(count <= `SFX_AE_OFS);
      raw.af_n    = !(count >= 4'(`SFX_DEPTH) - `SFX_AF_OFS);
      if (fall_through_mode) begin
         // output ready low when a word is shown
         raw.empty_n = !ov_d;
         // input ready low when room exists
         raw.full_n  = (count == 4'(`SFX_DEPTH));
      end
      // half full held inactive in the chain
      if (chain) begin
         raw.half_n = 1'b1;
      end
      st1_d = raw;
      flg_d = raw;
      // second stage adds one cycle of latency to the empty and full flags
      // chain uses the single stage only
      if (dbl_q && !chain) begin
         flg_d.empty_n = st1_q.empty_n;
         flg_d.full_n  = st1_q.full_n;
      end
   end

   // State registers
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_q <= MD_STD;
         dbl_q  <= 1'b0;
         wait_q <= 2'h0;
         cfg_q  <= 1'b0;
         wtok_q <= 1'b0;
         rtok_q <= 1'b0;
         ov_q   <= 1'b0;
         rdat_q <= 18'h0;
         st1_q  <= `SFX_FLAGS_RST;
         flg_q  <= `SFX_FLAGS_RST;
         wxo_q  <= 1'b1;
         rxo_q  <= 1'b1;
      end else begin
         mode_q <= mode_d;
         dbl_q  <= dbl_d;
         wait_q <= wait_d;
         cfg_q  <= cfg_d;
         wtok_q <= wtok_d;
         rtok_q <= rtok_d;
         ov_q   <= ov_d;
         rdat_q <= rdat_d;
         st1_q  <= st1_d;
         flg_q  <= flg_d;
         wxo_q  <= wxo_d;
         rxo_q  <= rxo_d;
      end
   end

   assign o_rd_data             = rdat_q;
   assign o_empty_flag_n        = flg_q.empty_n;
   assign o_full_flag_n         = flg_q.full_n;
   assign o_half_full_flag_n    = flg_q.half_n;
   assign o_almost_empty_flag_n = flg_q.ae_n;
   assign o_almost_full_flag_n  = flg_q.af_n;
   assign o_write_chain_out_n   = wxo_q;
   assign o_read_chain_out_n    = rxo_q;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   sequence tok_pulse_s(sig);
      !sig ##1 sig;
   endsequence

   cfg_chain_a: assert property ($rose(cfg_q) |->
      chain == ($past(s2_q.read_chain_in) && $past(s2_q.write_chain_in)))
      else $error("chain mode not taken from straps");
   cfg_fall_through_mode_a: assert property ($rose(cfg_q) |->
      fall_through_mode == (!$past(s2_q.read_chain_in) && $past(s2_q.write_chain_in)))
      else $error("fall-through not taken from straps");
   half_off_a: assert property (chain |->
      ##1 o_half_full_flag_n)
      else $error("half full shown in chain");
   chain_flag_a: assert property (chain && count == 4'h0
      |=> !o_empty_flag_n)
      else $error("chain empty flag not single stage");
   wr_pass_a: assert property (wr_last |=>
      tok_pulse_s(o_write_chain_out_n))
      else $error("write token pulse wrong");
   rd_pass_a: assert property (rd_last |=>
      tok_pulse_s(o_read_chain_out_n))
      else $error("read token pulse wrong");
   tok_gate_a: assert property (chain && !wtok_q |=>
      count <= $past(count))
      else $error("write taken without token");
   or_low_a: assert property (fall_through_mode && in_valid && in_ready
      && count == 4'h0 && !ov_q && !out_valid
      |-> ##2 !o_empty_flag_n)
      else $error("output ready late for first word");
   ir_low_a: assert property (fall_through_mode && count == 4'(`SFX_DEPTH)
      && out_ready && !in_valid |-> ##2 !o_full_flag_n)
      else $error("input ready not low after free slot");
endmodule : sfx_chain

/* File: verif/sfx_ring_model.sv */
// Model of the neighbouring devices on the token ring
`timescale 1ns/1ps
module sfx_ring_model import sfx_pkg::*; #(
   parameter int DLY = 24                // Ring round trip in cycles
) (
   input  wire logic       i_clk,        // Core clock
   input  wire logic       i_rst,        // Async reset, high
   input  wire sfx_strap_t i_strap,      // Strap levels
   input  wire logic       i_kick,       // Inject both tokens
   input  wire logic       i_wr_tok_n,   // Write token from block
   input  wire logic       i_rd_tok_n,   // Read token from block
   output logic            o_wr_tok_n,   // Write token to block
   output logic            o_rd_tok_n    // Read token to block
);
   logic [DLY-1:0] wsh_q;                // Write tokens in flight
   logic [DLY-1:0] rsh_q;                // Read tokens in flight
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wsh_q <= '0;
         rsh_q <= '0;
      end else begin
         wsh_q <= {wsh_q[DLY-2:0], ~i_wr_tok_n | i_kick};
         rsh_q <= {rsh_q[DLY-2:0], ~i_rd_tok_n | i_kick};
      end
   end
   assign o_wr_tok_n = i_strap.write_chain_in & ~wsh_q[DLY-1];
   assign o_rd_tok_n = i_strap.read_chain_in & ~rsh_q[DLY-1];
endmodule : sfx_ring_model

/* File: verif/tb_sfx_chain.sv */
// Self-checking bench of the FIFO expansion block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_sfx_chain import sfx_pkg::*; ;
   logic        i_core_clk;              // Core clock
   logic        i_sys_rst;               // Reset
   logic        i_wr_en;                 // Write request
   logic [17:0] i_wr_data;               // Write word
   logic        i_rd_en;                 // Read request
   logic        kick;                    // Token injection
   sfx_strap_t  strap;                   // Strap set
   logic        wci_n;                   // Write token in
   logic        rci_n;                   // Read token in
   logic [17:0] o_rd_data;               // Read word
   logic        empty_n;                 // Empty / out ready
   logic        full_n;                  // Full / in ready
   logic        half_n;                  // Half full
   logic        ae_n;                    // Almost empty
   logic        af_n;                    // Almost full
   logic        wco_n;                   // Write token out
   logic        rco_n;                   // Read token out
   int          fails;                   // Mismatches
   int          num_checks;              // Comparisons
   int          wco_cnt;                 // Write token pulse cycles
   int          rco_cnt;                 // Read token pulse cycles
   int          i;                       // Loop index
   logic [2:0]  sets [6];                // Standalone strap sets

   sfx_chain i_dut (
      .i_core_clk            (i_core_clk),
      .i_sys_rst             (i_sys_rst),
      .i_wr_en               (i_wr_en),
      .i_wr_data             (i_wr_data),
      .i_rd_en               (i_rd_en),
      .i_first_load_strap    (strap.fl),
      .i_read_chain_in_n     (rci_n),
      .i_write_chain_in_n    (wci_n),
      .o_rd_data             (o_rd_data),
      .o_empty_flag_n        (empty_n),
      .o_full_flag_n         (full_n),
      .o_half_full_flag_n    (half_n),
      .o_almost_empty_flag_n (ae_n),
      .o_almost_full_flag_n  (af_n),
      .o_write_chain_out_n   (wco_n),
      .o_read_chain_out_n    (rco_n)
   );
   sfx_ring_model #(.DLY(24)) i_ring (
      .i_clk      (i_core_clk),
      .i_rst      (i_sys_rst),
      .i_strap    (strap),
      .i_kick     (kick),
      .i_wr_tok_n (wco_n),
      .i_rd_tok_n (rco_n),
      .o_wr_tok_n (wci_n),
      .o_rd_tok_n (rci_n)
   );

   // Clock at 100 MHz
   // one free-running clock
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   // Count low cycles of the token outputs
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wco_cnt <= 0;
         rco_cnt <= 0;
      end else begin
         wco_cnt <= wco_cnt + int'(!wco_n);
         rco_cnt <= rco_cnt + int'(!rco_n);
      end
   end

   // Reset with straps, then wait past mode capture
   // straps fixed through reset
   task do_reset(input logic [2:0] s);
      @(posedge i_core_clk);
      i_sys_rst <= 1'b1;
      strap     <= sfx_strap_t'(s);
      repeat (12) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      @(negedge i_core_clk);
   endtask : do_reset
   // Back-to-back writes of counting words
   task wr_n(input int n, input logic [17:0] base);
      for (int k = 0; k < n; k++) begin
         @(posedge i_core_clk);
         i_wr_en   <= 1'b1;
         i_wr_data <= base + 18'(k);
      end
      @(posedge i_core_clk);
      i_wr_en <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      @(negedge i_core_clk);
   endtask : wr_n
   // Reads; shown word checked before or after the read
   task rd_chk(input int n, input logic [17:0] base, input logic ft);
      for (int k = 0; k < n; k++) begin
         @(negedge i_core_clk);
         if (ft) `CHK(o_rd_data, base + 18'(k))
         @(posedge i_core_clk);
         i_rd_en <= 1'b1;
         @(posedge i_core_clk);
         i_rd_en <= 1'b0;
         @(negedge i_core_clk);
         if (!ft) `CHK(o_rd_data, base + 18'(k))
      end
      repeat (3) @(posedge i_core_clk);
      @(negedge i_core_clk);
   endtask : rd_chk
   // Counts and verdict
   task results();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_core_clk);
      fails++;
      results();
   end

   initial begin
      i_sys_rst = 1'b1;
      i_wr_en = 1'b0;
      i_wr_data = '0;
      i_rd_en = 1'b0;
      kick = 1'b0;
      strap = '0;
      fails = 0;
      num_checks = 0;
      sets = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
      // Each standalone set moves a word, with no tokens
      for (i = 0; i < 6; i++) begin
         do_reset(sets[i]);
         `CHK(empty_n, strap.write_chain_in & ~strap.read_chain_in)
         wr_n(1, 18'h3a5 ^ 18'(i));
         rd_chk(1, 18'h3a5 ^ 18'(i), strap.write_chain_in & ~strap.read_chain_in);
      end
      // Double stage: empty lifts one cycle after single
      do_reset(3'h2);
      @(posedge i_core_clk);
      i_wr_en <= 1'b1;
      @(posedge i_core_clk);
      i_wr_en <= 1'b0;
      @(negedge i_core_clk);
      `CHK(empty_n, 1'b0)
      @(negedge i_core_clk);
      `CHK(empty_n, 1'b0)
      @(negedge i_core_clk);
      `CHK(empty_n, 1'b1)
      // Standard: thresholds, full, refused write, drain
      do_reset(3'h0);
      wr_n(5, 18'h100);
      `CHK(half_n, 1'b0)
      `CHK(af_n, 1'b1)
      wr_n(3, 18'h105);
      `CHK(full_n, 1'b0)
      `CHK(af_n, 1'b0)
      `CHK(wco_cnt, 1)
      wr_n(1, 18'h2ff);
      rd_chk(8, 18'h100, 1'b0);
      `CHK(rco_cnt, 1)
      `CHK(empty_n, 1'b0)
      `CHK(ae_n, 1'b0)
      rd_chk(1, 18'h107, 1'b0);
      // Chain, first device: tokens leave and return
      do_reset(3'h3);
      wr_n(8, 18'h200);
      `CHK(wco_cnt, 1)
      `CHK(half_n, 1'b1)
      rd_chk(1, 18'h200, 1'b0);
      wr_n(1, 18'h2ee);
      repeat (30) @(posedge i_core_clk);
      wr_n(1, 18'h208);
      rd_chk(7, 18'h201, 1'b0);
      `CHK(rco_cnt, 1)
      repeat (30) @(posedge i_core_clk);
      rd_chk(1, 18'h208, 1'b0);
      // Chain, later device: nothing until tokens arrive
      do_reset(3'h7);
      wr_n(1, 18'h311);
      `CHK(empty_n, 1'b0)
      @(posedge i_core_clk);
      kick <= 1'b1;
      @(posedge i_core_clk);
      kick <= 1'b0;
      repeat (30) @(posedge i_core_clk);
      wr_n(1, 18'h322);
      `CHK(empty_n, 1'b1)
      rd_chk(1, 18'h322, 1'b0);
      // Fall-through: first word, nine words, freed slot
      do_reset(3'h5);
      wr_n(1, 18'h3c0);
      `CHK(empty_n, 1'b0)
      `CHK(o_rd_data, 18'h3c0)
      wr_n(8, 18'h3c1);
      `CHK(full_n, 1'b1)
      rd_chk(1, 18'h3c0, 1'b1);
      `CHK(full_n, 1'b0)
      rd_chk(8, 18'h3c1, 1'b1);
      `CHK(empty_n, 1'b1)
      results();
   end
endmodule : tb_sfx_chain
